// File: asrp_ctrl.sv
// conversion sequencing control: sync, reset, power-down, standby and final high-pass stage
// assumes command pulses come from serial-port logic on clk; pins are asynchronous
// How it works
// - last filter step is first-order recursive high-pass with gain (2-a)/2
// - coefficient a comes from a sixteen-bit corner value scaled by 65536
// - all conversion timing counts master-clock rising edges only
// - align comes from pin or command, in pulse or periodic mode
// - pulse-mode align restarts conversion, clears filter, holds strobe high
// - pin align acts on next master edge; command after its eighth serial edge
// - fir path: ready after 62.98046875 periods plus 468 master cycles
// - sinc path: ready after 440/616/968/1672/2824 cycles for 128k..8k
// - command events count from next master edge; resume two cycles less
// - periodic mode resyncs on the first edge or when edge spacing is not a period multiple
// - periodic resync keeps strobe running, holds serial output low 63 periods
// - in periodic mode a config write resyncs and drops pin alignment
// - standby then resume regains pin alignment if gap is off-multiple
// - reset pin low two master periods resets; held while low
// - reset command acts on the master edge after its eighth serial edge
// - any reset restores config defaults and restarts conversions
// - power-down pin resets config, state, filter and align flags; standby keeps port and config alive
// - chip-select high ends standby
// - after power-on or power-down release: fir path at 1000 samples/s
// - internal reset released after 2^16 master cycles
// - serial clock low for 64 strobe periods resets the serial port
`timescale 1ns/1ps
`include "asrp_defs.svh"
module asrp_ctrl
#(
	parameter int POR_MCLK = `ASRP_POR_MCLK
)
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               mclk_pin,
	input  wire logic               align_pin,
	input  wire logic               reset_pin_n,
	input  wire logic               powerdown_pin_n,
	input  wire logic               cs_pin_n,
	input  wire logic               sclk_pin,
	input  wire logic               cmd_sync,
	input  wire logic               cmd_reset,
	input  wire logic               cmd_standby,
	input  wire logic               resume_cmd,
	input  wire logic               cfg_write,
	input  wire logic               cfg_fir,
	input  wire logic [2:0]         cfg_rate,
	input  wire logic               cfg_periodic,
	input  wire logic [15:0]        cfg_hp,
	input  wire logic               read_ack,
	input  wire asrp_pkg::asrp_sample_type sample_in,
	input  wire logic               sample_valid,
	output asrp_pkg::asrp_sample_type hp_out,
	output logic                    hp_valid,
	output logic                    data_ready_strobe_n,
	output logic                    dout_force_low,
	output logic                    filter_clear,
	output logic                    port_reset,
	output logic                    powered,
	output logic                    standby,
	output logic                    fir_sel,
	output logic [2:0]              rate_sel,
	output logic                    periodic_sel,
	output logic [15:0]             highpass_corner_coeff
);
	import asrp_pkg::*;

	// --------------------------------------------------------------
	// rate arithmetic
	// --------------------------------------------------------------
	// conversion period in master cycles
	function automatic logic [14:0] period_of(input logic fir, input logic [2:0] code);
		logic [14:0] base;
		base = fir ? `ASRP_FIR_BASE : `ASRP_SINC_BASE;
		period_of = base >> code;
	endfunction

	// master cycles from restart to first data
	function automatic logic [20:0] delay_of(input logic fir, input logic [2:0] code);
		logic [35:0] prod;
		prod = 36'(`ASRP_FIR_NUM) * 36'(period_of(fir, code));
		if (fir)
			delay_of = 21'(prod >> 8) + `ASRP_FIR_ADD;
		else
			unique case (code)
				3'h0:    delay_of = `ASRP_SINC_D0;
				3'h1:    delay_of = `ASRP_SINC_D1;
				3'h2:    delay_of = `ASRP_SINC_D2;
				3'h3:    delay_of = `ASRP_SINC_D3;
				default: delay_of = `ASRP_SINC_D4;
			endcase
	endfunction

	// --------------------------------------------------------------
	// pin sampling
	// --------------------------------------------------------------
	logic [5:0]      s1_r;
	logic [5:0]      s2_r;
	logic [5:0]      s3_r;
	logic [5:0]      lvl_r;
	logic [5:0]      lvl_nxt;
	logic [5:0]      rise;
	logic            mtick;

	// three stages; a level changes once stages two and three agree
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_r  <= `ASRP_PIN_IDLE;
			s2_r  <= `ASRP_PIN_IDLE;
			s3_r  <= `ASRP_PIN_IDLE;
			lvl_r <= `ASRP_PIN_IDLE;
		end
		else
		begin
			s1_r  <= {sclk_pin, cs_pin_n, powerdown_pin_n, reset_pin_n, align_pin, mclk_pin};
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
	assign rise    = lvl_nxt & ~lvl_r;
	assign mtick   = rise[`ASRP_PIN_MCLK];

	// --------------------------------------------------------------
	// configuration and pending events
	// --------------------------------------------------------------
	asrp_state_type  state_r;
	logic [14:0]     period;
	logic            do_reset;
	logic            pend_align_r;
	logic            pend_sync_r;
	logic            pend_reset_r;
	logic            pend_stby_r;
	logic            pend_res_r;
	logic            pend_cfg_r;

	assign period   = period_of(fir_sel, rate_sel);
	assign powered  = lvl_r[`ASRP_PIN_POWERDOWN_PIN];
	assign standby  = (state_r == ST_STANDBY);
	assign do_reset = ~lvl_r[`ASRP_PIN_RST] | pend_reset_r;

	// config: defaults on any reset, written only while powered
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fir_sel               <= `ASRP_DEF_FIR;
			rate_sel              <= `ASRP_DEF_RATE;
			periodic_sel          <= `ASRP_DEF_PERIODIC;
			highpass_corner_coeff <= `ASRP_DEF_HP;
		end
		else if (!powered || (mtick && do_reset))
		begin
			fir_sel               <= `ASRP_DEF_FIR;
			rate_sel              <= `ASRP_DEF_RATE;
			periodic_sel          <= `ASRP_DEF_PERIODIC;
			highpass_corner_coeff <= `ASRP_DEF_HP;
		end
		else if (cfg_write && state_r != ST_POR)
		begin
			fir_sel               <= cfg_fir;
			rate_sel              <= cfg_rate;
			periodic_sel          <= cfg_periodic;
			highpass_corner_coeff <= cfg_hp;
		end
	end

	// events wait for the next master edge; a new event wins over the clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pend_align_r <= 1'b0;
			pend_sync_r  <= 1'b0;
			pend_reset_r <= 1'b0;
			pend_stby_r  <= 1'b0;
			pend_res_r   <= 1'b0;
			pend_cfg_r   <= 1'b0;
		end
		else
		begin
			pend_align_r <= rise[`ASRP_PIN_ALIGN] | (pend_align_r & ~mtick);
			pend_sync_r  <= cmd_sync | (pend_sync_r & ~mtick);
			pend_reset_r <= cmd_reset | (pend_reset_r & ~mtick);
			pend_stby_r  <= cmd_standby | (pend_stby_r & ~mtick);
			pend_res_r   <= resume_cmd | (pend_res_r & ~mtick);
			pend_cfg_r   <= (cfg_write & periodic_sel) | (pend_cfg_r & ~mtick);
		end
	end

	// --------------------------------------------------------------
	// alignment tracking
	// --------------------------------------------------------------
	logic [14:0]     interval_r;
	logic [14:0]     gap_r;
	logic            first_r;
	logic            pin_lost_r;
	logic            pin_sync;
	logic            periodic_sync;
	logic            pulse_sync;

	// periodic mode: resync on first edge or off-multiple spacing
	assign pin_sync      = pend_align_r & ~pin_lost_r & (first_r | interval_r != 15'h0);
	assign periodic_sync = periodic_sel & (pin_sync | pend_sync_r | pend_cfg_r);
	assign pulse_sync    = ~periodic_sel & (pend_align_r | pend_sync_r);

	// spacing between align edges, modulo the period
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			interval_r <= 15'h0;
		else if (mtick)
			if (pend_align_r)
				interval_r <= 15'h1; // acting edge is tick zero, next tick reads one
			else if (interval_r >= period - 15'h1)
				interval_r <= 15'h0;
			else
				interval_r <= interval_r + 15'h1;
	end

	// standby duration, modulo the period
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			gap_r <= 15'h0;
		else if (mtick)
			if (state_r != ST_STANDBY)
				gap_r <= 15'h1; // entry tick is zero, so the first standby tick reads one
			else if (gap_r >= period - 15'h1)
				gap_r <= 15'h0;
			else
				gap_r <= gap_r + 15'h1;
	end

	// first-edge and lost-alignment flags
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			first_r    <= 1'b1;
			pin_lost_r <= 1'b0;
		end
		else if (!periodic_sel || !powered || (mtick && do_reset))
		begin
			first_r    <= 1'b1;
			pin_lost_r <= 1'b0;
		end
		else if (mtick)
		begin
			if (pend_cfg_r)
				pin_lost_r <= 1'b1;
			else if (standby && pend_res_r && gap_r != 15'h0)
			begin
				pin_lost_r <= 1'b0;
				first_r    <= 1'b1;
			end
			else if (pin_sync)
				first_r <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// sequencing
	// --------------------------------------------------------------
	logic [16:0]     por_r;
	logic [20:0]     settle_r;
	logic [14:0]     phase_r;
	logic            restart;
	logic            wake;

	assign wake    = standby && (lvl_r[`ASRP_PIN_CS] || pend_res_r);
	assign restart = do_reset | (pulse_sync & state_r != ST_STANDBY);

	// power, reset, settle, run and standby states
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r  <= ST_POR;
			por_r    <= 17'h0;
			settle_r <= 21'h0;
		end
		else if (!powered)
		begin
			state_r <= ST_OFF;
			por_r   <= 17'h0;
		end
		else if (mtick)
		begin
			unique case (state_r)
				ST_OFF:
					state_r <= ST_POR;
				ST_POR:
				begin
					por_r <= por_r + 17'h1;
					if (por_r >= 17'(POR_MCLK - 1))
					begin
						state_r  <= ST_SETTLE;
						settle_r <= delay_of(fir_sel, rate_sel);
					end
				end
				ST_SETTLE, ST_RUN:
					if (restart)
					begin
						state_r  <= ST_SETTLE;
						settle_r <= delay_of(do_reset ? `ASRP_DEF_FIR : fir_sel,
							do_reset ? `ASRP_DEF_RATE : rate_sel);
					end
					else if (pend_stby_r)
						state_r <= ST_STANDBY;
					else if (state_r == ST_SETTLE)
					begin
						settle_r <= settle_r - 21'h1;
						// run one tick early: the strobe falls on the tick after
						if (settle_r <= 21'h2)
							state_r <= ST_RUN;
					end
				ST_STANDBY:
					if (do_reset || wake)
					begin
						state_r  <= ST_SETTLE;
						settle_r <= delay_of(fir_sel, rate_sel)
							- ((pend_res_r && !do_reset) ? `ASRP_WAKE_SUB : 21'h0);
					end
			endcase
		end
	end

	// conversion phase within the period; periodic resync restarts it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			phase_r <= 15'h0;
		else if (mtick)
			if (state_r != ST_RUN || periodic_sync || phase_r >= period - 15'h1)
				phase_r <= 15'h0;
			else
				phase_r <= phase_r + 15'h1;
	end

	// --------------------------------------------------------------
	// strobe, output hold and serial timeout
	// --------------------------------------------------------------
	logic [5:0]      hold_r;
	logic [6:0]      tmo_r;
	logic            period_end;

	assign period_end = mtick && state_r == ST_RUN && phase_r == 15'h0;

	// strobe low from period start, high for the last four cycles and from a restart edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			data_ready_strobe_n <= 1'b1;
		else if (state_r != ST_RUN || (mtick && (restart || pend_stby_r)))
			data_ready_strobe_n <= 1'b1;
		else if (period_end)
			data_ready_strobe_n <= 1'b0;
		else if (read_ack || phase_r >= period - `ASRP_UPDATE_GAP)
			data_ready_strobe_n <= 1'b1;
	end

	// serial output held low for 63 strobe periods after periodic resync
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hold_r <= 6'h0;
		else if (mtick && periodic_sync && state_r == ST_RUN)
			hold_r <= `ASRP_HOLD_PERIODS;
		else if (period_end && hold_r != 6'h0)
			hold_r <= hold_r - 6'h1;
	end

	assign dout_force_low = (hold_r != 6'h0);

	// serial port reset after 64 strobe periods of serial clock low
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tmo_r      <= 7'h0;
			port_reset <= 1'b0;
		end
		else
		begin
			port_reset <= 1'b0;
			if (lvl_r[`ASRP_PIN_SCLK] || lvl_r[`ASRP_PIN_CS])
				tmo_r <= 7'h0;
			else if (period_end)
			begin
				if (tmo_r >= `ASRP_SCLK_TMO - 7'h1)
				begin
					tmo_r      <= 7'h0;
					port_reset <= 1'b1;
				end
				else
					tmo_r <= tmo_r + 7'h1;
			end
		end
	end

	// --------------------------------------------------------------
	// final high-pass stage
	// --------------------------------------------------------------
	logic [16:0]     one_m_a;
	logic [33:0]     sq;
	logic [16:0]     b_q;
	logic [16:0]     g_q;
	logic [32:0]     diff;
	logic [31:0]     x_prev_r;
	logic [49:0]     acc;

	// b = (1 + (1-a)^2)/2, gain = 1 - a/2, fractions over 65536
	assign one_m_a = 17'h10000 - 17'(highpass_corner_coeff);
	assign sq      = 34'(one_m_a) * 34'(one_m_a);
	assign b_q     = 17'((34'h100000000 + sq) >> 17);
	assign g_q     = 17'h10000 - 17'(highpass_corner_coeff >> 1);
	assign diff    = 33'($signed(sample_in)) - 33'($signed(x_prev_r));
	assign acc     = $signed(50'($signed(hp_out))) * $signed({33'h0, b_q})
		+ $signed(50'($signed(diff))) * $signed({33'h0, g_q});
	assign filter_clear = mtick && (standby ? (do_reset || wake) : restart);

	// memory cleared on restart
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			x_prev_r <= 32'h0;
			hp_out   <= 32'h0;
			hp_valid <= 1'b0;
		end
		else if (filter_clear || state_r == ST_OFF)
		begin
			x_prev_r <= 32'h0;
			hp_out   <= 32'h0;
			hp_valid <= 1'b0;
		end
		else
		begin
			hp_valid <= sample_valid;
			if (sample_valid)
			begin
				x_prev_r <= sample_in;
				hp_out   <= 32'($signed(acc) >>> 16);
			end
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	strobe_in_settle_a: assert property (state_r == ST_SETTLE |-> data_ready_strobe_n)
		else $error("strobe low while settling");
	pend_at_tick_a: assert property (mtick |=> !pend_sync_r || $past(cmd_sync))
		else $error("sync command not consumed at master edge");
	reset_defaults_a: assert property (mtick && do_reset && powered |=> fir_sel && rate_sel == 3'h2)
		else $error("reset did not restore defaults");
	powerdown_pin_off_a: assert property (!powered |=> state_r == ST_OFF)
		else $error("power-down pin did not stop device");
	hold_load_a: assert property (mtick && periodic_sync && state_r == ST_RUN |=> hold_r == 6'h3f)
		else $error("output hold not loaded with 63");
	cs_wake_a: assert property (mtick && standby && lvl_r[`ASRP_PIN_CS] && powered && !do_reset
		|=> state_r == ST_SETTLE)
		else $error("chip-select high did not end standby");
	period_match_a: assert property (mtick && pend_align_r && periodic_sel && !first_r
		&& interval_r == 15'h0 && !pend_sync_r && !pend_cfg_r |-> !periodic_sync)
		else $error("resync on matching period");
	settle_run_a: assert property (mtick && state_r == ST_SETTLE && settle_r == 21'h2
		&& !restart && !pend_stby_r && powered |=> state_r == ST_RUN)
		else $error("settle did not end in run");
	tmo_pulse_a: assert property (port_reset |=> !port_reset)
		else $error("port reset longer than one cycle");

	run_cov: cover property (state_r == ST_SETTLE ##1 state_r == ST_RUN);
	resync_cov: cover property (mtick && periodic_sync && state_r == ST_RUN);
	standby_cov: cover property (standby ##[1:1000] state_r == ST_SETTLE);
endmodule

// File: asrp_defs.svh
// offsets, field values, reset values and counts for the sync/reset/power-down control
// assumes one 40 MHz system clock and a master clock pin sampled inside it
`ifndef ASRP_DEFS_SVH
`define ASRP_DEFS_SVH
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define ASRP_CLK_MHZ      40
`define ASRP_MCLK_KHZ     4096
`define ASRP_POR_MCLK     65536
`define ASRP_FIR_BASE     15'h4000
`define ASRP_SINC_BASE    15'h0200
`define ASRP_FIR_NUM      21'h003efb
`define ASRP_FIR_ADD      21'h0001d4
`define ASRP_WAKE_SUB     21'h000002
`define ASRP_HOLD_PERIODS 6'h3f
`define ASRP_SCLK_TMO     7'h40
`define ASRP_UPDATE_GAP   15'h0004
// --------------------------------------------------------------
// sinc data-ready delays, indexed by rate code 0..4 (8k..128k)
// --------------------------------------------------------------
`define ASRP_SINC_D0      21'h000b08
`define ASRP_SINC_D1      21'h000688
`define ASRP_SINC_D2      21'h0003c8
`define ASRP_SINC_D3      21'h000268
`define ASRP_SINC_D4      21'h0001b8
// --------------------------------------------------------------
// defaults and pin layout
// --------------------------------------------------------------
`define ASRP_DEF_FIR      1'b1
`define ASRP_DEF_RATE     3'h2
`define ASRP_DEF_PERIODIC 1'b0
`define ASRP_DEF_HP       16'h0000
`define ASRP_PIN_MCLK     0
`define ASRP_PIN_ALIGN    1
`define ASRP_PIN_RST      2
`define ASRP_PIN_POWERDOWN_PIN     3
`define ASRP_PIN_CS       4
`define ASRP_PIN_SCLK     5
`define ASRP_PIN_IDLE     6'h1c
`endif

// File: asrp_pkg.sv
// types shared by the sync/reset/power-down control
// assumes nothing beyond the defs header
package asrp_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_POR, ST_SETTLE, ST_RUN, ST_STANDBY} asrp_state_type;
	typedef logic [31:0] asrp_sample_type;
endpackage

// File: asrp_host_model.sv
// host-side model: master clock source and align pin driver
// assumes the bench calls align_pulse from a single process
`timescale 1ns/1ps
module asrp_host_model
#(
	parameter int HALF_NS = 100
)
(
	output logic mclk_pin,
	output logic align_pin
);
	// --------------------------------------------------------------
	// master clock
	// --------------------------------------------------------------
	// free running like an oscillator, so it has no idle level
	initial
	begin
		mclk_pin = 1'h0;
		align_pin = 1'h0;
		forever #(HALF_NS) mclk_pin = ~mclk_pin;
	end
	// --------------------------------------------------------------
	// align pin
	// --------------------------------------------------------------
	// rise lands a quarter period after a master rise, clear of the master edge; rises are spaced ticks periods
	task automatic align_pulse(input int ticks);
		@(posedge mclk_pin);
		#(HALF_NS / 2) align_pin = 1'h1;
		repeat (2) @(posedge mclk_pin);
		#(HALF_NS / 2) align_pin = 1'h0;
		repeat (ticks - 3) @(posedge mclk_pin);
	endtask
endmodule

// File: asrp_ctrl_tb.sv
// self-checking bench for asrp_ctrl: restarts, delays, pins, periodic align, high-pass
// assumes asrp_pkg, asrp_ctrl and asrp_host_model are compiled before it
`timescale 1ns/1ps
`define chk(nm, ex, gt) \
	begin \
		total_checks++; \
		if ((gt) !== (ex)) \
		begin \
			err_total++; \
			$display("unexpected %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end
module asrp_ctrl_tb;
	import asrp_pkg::*;
	logic                 clk             = 1'h0;
	logic                 rst             = 1'h1;
	logic                 reset_pin_n     = 1'h1;
	logic                 powerdown_pin_n = 1'h1;
	logic                 cs_pin_n        = 1'h0;
	logic                 sclk_pin        = 1'h0;
	logic                 read_ack        = 1'h0;
	logic [4:0]           cmd_v           = 5'h00;
	logic                 cfg_fir         = 1'h1;
	logic [2:0]           cfg_rate        = 3'h2;
	logic                 cfg_periodic    = 1'h0;
	logic [15:0]          cfg_hp          = 16'h0000;
	asrp_sample_type      sample_in       = 32'h00000000;
	logic                 sample_valid    = 1'h0;
	wire                  mclk_pin;
	wire                  align_pin;
	asrp_sample_type      hp_out;
	logic                 hp_valid;
	logic                 data_ready_strobe_n;
	logic                 dout_force_low;
	logic                 filter_clear;
	logic                 port_reset;
	logic                 powered;
	logic                 standby;
	logic                 fir_sel;
	logic [2:0]           rate_sel;
	logic                 periodic_sel;
	logic [15:0]          highpass_corner_coeff;
	int                   err_total       = 0;
	int                   total_checks    = 0;
	int                   falls           = 0;
	logic                 strobe_d        = 1'h1;
	logic                 prst_seen       = 1'h0;

	// 40 MHz system clock
	initial
	begin
		forever #12.5 clk = ~clk;
	end

	asrp_host_model u_asrp_host_model (.mclk_pin(mclk_pin), .align_pin(align_pin));

	asrp_ctrl #(.POR_MCLK(16)) u_asrp_ctrl (
		.clk(clk), .rst(rst), .mclk_pin(mclk_pin), .align_pin(align_pin),
		.reset_pin_n(reset_pin_n), .powerdown_pin_n(powerdown_pin_n),
		.cs_pin_n(cs_pin_n), .sclk_pin(sclk_pin), .cmd_sync(cmd_v[0]),
		.cmd_reset(cmd_v[1]), .cmd_standby(cmd_v[2]), .resume_cmd(cmd_v[3]),
		.cfg_write(cmd_v[4]), .cfg_fir(cfg_fir), .cfg_rate(cfg_rate),
		.cfg_periodic(cfg_periodic), .cfg_hp(cfg_hp), .read_ack(read_ack),
		.sample_in(sample_in), .sample_valid(sample_valid), .hp_out(hp_out),
		.hp_valid(hp_valid), .data_ready_strobe_n(data_ready_strobe_n),
		.dout_force_low(dout_force_low), .filter_clear(filter_clear),
		.port_reset(port_reset), .powered(powered), .standby(standby),
		.fir_sel(fir_sel), .rate_sel(rate_sel), .periodic_sel(periodic_sel),
		.highpass_corner_coeff(highpass_corner_coeff));

	// strobe fall counter and serial timeout watcher
	always @(posedge clk)
	begin
		strobe_d <= data_ready_strobe_n;
		if (port_reset === 1'h1)
			prst_seen <= 1'h1;
		if (strobe_d === 1'h1 && data_ready_strobe_n === 1'h0)
			falls <= falls + 1;
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic int sinc_delay(input int r);
		int t[5] = '{2824, 1672, 968, 616, 440};
		return t[r];
	endfunction

	task automatic final_report();
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one-cycle command pulse
	task automatic fire(input logic [4:0] m);
		@(posedge clk) cmd_v <= m;
		@(posedge clk) cmd_v <= 5'h00;
	endtask

	// wait master ticks, land off the clock edge
	task automatic ticks(input int n);
		repeat (n) @(posedge mclk_pin);
		#1;
	endtask

	task automatic set_cfg(input logic f, input logic [2:0] r, input logic p,
		input logic [15:0] h);
		@(posedge clk);
		cfg_fir <= f;
		cfg_rate <= r;
		cfg_periodic <= p;
		cfg_hp <= h;
		fire(5'h10);
		ticks(4);
		`chk("fir_sel", f, fir_sel)
		`chk("rate_sel", r, rate_sel)
		`chk("periodic_sel", p, periodic_sel)
		`chk("hp coeff", h, highpass_corner_coeff)
	endtask

	task automatic chk_defaults();
		`chk("fir_sel", 1'h1, fir_sel)
		`chk("rate_sel", 3'h2, rate_sel)
		`chk("periodic_sel", 1'h0, periodic_sel)
		`chk("hp coeff", 16'h0000, highpass_corner_coeff)
	endtask

	// restart by command, then count master rises until the strobe falls
	task automatic measure(input logic [4:0] m, input int d);
		int n;
		int k;
		logic mprev;
		n = 0;
		fire(m);
		for (k = 0; k < 200 && filter_clear !== 1'h1; k++)
			@(negedge clk);
		`chk("filter clear", 1'h1, filter_clear)
		if (k == 200)
			final_report();
		// let the restart edge pass so a strobe still low from the old run is not counted
		@(negedge clk);
		mprev = mclk_pin;
		for (k = 0; k < (d + 4) * 8 && data_ready_strobe_n !== 1'h0; k++)
		begin
			@(negedge clk);
			n += (mclk_pin && !mprev) ? 1 : 0;
			mprev = mclk_pin;
		end
		`chk("ready ticks", d, n)
		if (k == (d + 4) * 8)
			final_report();
	endtask

	// --------------------------------------------------------------
	// watchdog
	// --------------------------------------------------------------
	initial
	begin
		repeat (100000) @(posedge clk);
		err_total++;
		final_report();
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial
	begin
		int i;
		int f0;
		asrp_sample_type x;
		i = $urandom(32'h57cd49a9);
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1;
		chk_defaults();
		`chk("strobe", 1'h1, data_ready_strobe_n)
		`chk("powered", 1'h1, powered)
		ticks(20);
		// sinc delays at every rate
		for (i = 0; i < 5; i++)
		begin
			set_cfg(1'h0, i[2:0], 1'h0, 16'h0000);
			measure(5'h01, sinc_delay(i));
		end
		// zero corner gives b = 1 and unity gain: output follows input
		for (i = 0; i < 8; i++)
		begin
			x = asrp_sample_type'($urandom_range(32'h00ffffff)) - 32'h00800000;
			@(posedge clk);
			sample_in <= x;
			sample_valid <= 1'h1;
			@(posedge clk);
			sample_valid <= 1'h0;
			#1;
			`chk("hp_valid", 1'h1, hp_valid)
			`chk("hp_out", x, hp_out)
		end
		// standby keeps config, chip-select ends it, resume is two ticks shorter
		fire(5'h04);
		ticks(3);
		`chk("standby", 1'h1, standby)
		`chk("rate_sel", 3'h4, rate_sel)
		@(posedge clk) cs_pin_n <= 1'h1;
		ticks(3);
		`chk("standby", 1'h0, standby)
		@(posedge clk) cs_pin_n <= 1'h0;
		ticks(4);
		fire(5'h04);
		ticks(4);
		measure(5'h08, sinc_delay(4) - 2);
		// periodic mode, rearmed by standby/resume with an off-multiple gap
		set_cfg(1'h0, 3'h4, 1'h1, 16'h0000);
		fire(5'h04);
		ticks(37);
		measure(5'h08, sinc_delay(4) - 2);
		repeat (70) u_asrp_host_model.align_pulse(32);
		`chk("dout hold", 1'h0, dout_force_low)
		`chk("port timeout", 1'h1, prst_seen)
		u_asrp_host_model.align_pulse(33);
		f0 = falls;
		u_asrp_host_model.align_pulse(8);
		`chk("dout hold", 1'h1, dout_force_low)
		ticks(70);
		`chk("strobe runs", 1'h1, (falls - f0 >= 2))
		// reset command, reset pin, power-down pin
		set_cfg(1'h0, 3'h1, 1'h0, 16'($urandom));
		fire(5'h02);
		ticks(4);
		chk_defaults();
		ticks(20);
		set_cfg(1'h0, 3'($urandom % 5), 1'h0, 16'($urandom));
		@(posedge clk) reset_pin_n <= 1'h0;
		ticks(3);
		chk_defaults();
		@(posedge clk) reset_pin_n <= 1'h1;
		ticks(20);
		set_cfg(1'h0, 3'h3, 1'h1, 16'($urandom));
		@(posedge clk) powerdown_pin_n <= 1'h0;
		ticks(3);
		`chk("powered", 1'h0, powered)
		chk_defaults();
		@(posedge clk) powerdown_pin_n <= 1'h1;
		ticks(3);
		`chk("powered", 1'h1, powered)
		chk_defaults();
		final_report();
	end
endmodule
